/* File: shared/reset_seq_pkg.sv */
package reset_seq_pkg;
  localparam int unsigned POR_STRETCH_CYC = 64;
  localparam int unsigned SYNC_RST_CYC    = 3;
  localparam int unsigned CLKGEN_DLY_CYC  = 32;
  localparam int unsigned PERIPH_DLY_CYC  = 32;
  localparam int unsigned CORE_DLY_CYC    = 32;
  localparam int unsigned CNT_W           = 7;
  localparam logic        RST_ASSERTED_N  = 1'b0;
endpackage : reset_seq_pkg

/* File: src/reset_extender.sv */
`timescale 1ns/1ns
module reset_extender
  import reset_seq_pkg::*;
#(
  parameter int unsigned DELAY = 32,
  parameter int unsigned CW    = 7
) (
  input  wire logic clk,
  input  wire logic in_rst_n,
  input  wire logic hold,
  output logic      out_rst_n
);
  if (DELAY < 1 || DELAY >= (1 << CW)) begin : g_bad_delay
    $error("reset_extender: delay out of range");
  end

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          done_w;

  assign done_w  = (cnt_r == CW'(DELAY));
  assign cnt_nxt = done_w ? cnt_r : cnt_r + CW'(1);

  // async assert, counted release; hold freezes the count without asserting
  always_ff @(posedge clk or negedge in_rst_n) begin
    if (!in_rst_n) begin
      cnt_r <= '0;
    end else if (!hold) begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(negedge clk or negedge in_rst_n) begin
    if (!in_rst_n) begin
      out_rst_n <= RST_ASSERTED_N;
    end else begin
      out_rst_n <= done_w;
    end
  end
endmodule : reset_extender

/* File: src/phased_reset_release_sequencer.sv */
`timescale 1ns/1ns
// Summary of operation
// - five sources: pin, power-on async; others sync
// - test port reset only by power-on
// - power-on stretched 64 oscillator clocks
// - combined reset ORs all; holds everything but the test port and the stretched power-on reset
// - combined release starts control, sync, clock extenders
// - software/watchdog logic released three clocks later
// - clock generator reset released after 32 clocks
// - clock generator release on oscillator falling edge
// - peripheral reset 32 system clocks later
// - core reset 32 system clocks after peripheral
// - peripheral, core released on delayed clock fall
// - core release starts code execution
// - early delays count on oscillator clock
// - one common clock; timers, modulator optional triple
// - no interrupt requests raised
module phased_reset_release_sequencer
  import reset_seq_pkg::*;
#(
  parameter int unsigned POR_CYC    = POR_STRETCH_CYC,
  parameter int unsigned SYNC_CYC   = SYNC_RST_CYC,
  parameter int unsigned CLKGEN_CYC = CLKGEN_DLY_CYC,
  parameter int unsigned PERIPH_CYC = PERIPH_DLY_CYC,
  parameter int unsigned CORE_CYC   = CORE_DLY_CYC
) (
  input  wire logic mclk,
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic ext_rst_n,
  input  wire logic sw_reset_req,
  input  wire logic watchdog_timeout_reset,
  input  wire logic watchdog_lost_reference_reset,
  input  wire logic fast_clk_sel,
  output logic      tap_rst_n,
  output logic      ext_por_rst_n,
  output logic      combined_rst_n,
  output logic      sync_logic_rst_n,
  output logic      clock_generator_reset_n,
  output logic      peripheral_reset_n,
  output logic      core_rst_n,
  output logic      core_run,
  output logic      fast_timer_clk_en,
  output logic      irq
);
  import reset_seq_pkg::*;

  localparam int unsigned CNT_MAX = (1 << CNT_W) - 1;

  if (POR_CYC < 1 || POR_CYC > CNT_MAX) begin : g_bad_por
    $error("power-on count out of range");
  end
  if (SYNC_CYC < 1 || SYNC_CYC > CNT_MAX) begin : g_bad_sync
    $error("sync count out of range");
  end
  if (CLKGEN_CYC < 1 || CLKGEN_CYC > CNT_MAX) begin : g_bad_clkgen
    $error("clock generator count out of range");
  end
  if (PERIPH_CYC < 1 || PERIPH_CYC > CNT_MAX) begin : g_bad_periph
    $error("peripheral count out of range");
  end
  if (CORE_CYC < 1 || CORE_CYC > CNT_MAX) begin : g_bad_core
    $error("core count out of range");
  end

  // mclk is the oscillator clock; rst_n is the raw power-on reset
  logic sync_src_r;
  logic sync_src_nxt;
  logic clkgen_w;
  logic periph_w;
  logic core_w;

  assign tap_rst_n = rst_n;
  assign irq       = 1'b0;

  reset_extender #(.DELAY(POR_CYC), .CW(CNT_W)) u_por (
    .clk       (mclk),
    .in_rst_n  (rst_n),
    .hold      (1'b0),
    .out_rst_n (ext_por_rst_n)
  );

  // sync request latched until the sync generator holds it in reset
  assign sync_src_nxt = sync_logic_rst_n & (sync_src_r | sw_reset_req |
                        watchdog_timeout_reset | watchdog_lost_reference_reset);
  // no async clear from combined reset: that loop would cut its own pulse to a glitch
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync_src_r <= 1'b0;
    end else begin
      sync_src_r <= sync_src_nxt;
    end
  end

  assign combined_rst_n = ext_por_rst_n & ext_rst_n & ~sync_src_r;

  reset_extender #(.DELAY(SYNC_CYC), .CW(CNT_W)) u_sync (
    .clk       (mclk),
    .in_rst_n  (combined_rst_n),
    .hold      (1'b0),
    .out_rst_n (sync_logic_rst_n)
  );

  reset_extender #(.DELAY(CLKGEN_CYC), .CW(CNT_W)) u_clkgen (
    .clk       (mclk),
    .in_rst_n  (combined_rst_n),
    .hold      (1'b0),
    .out_rst_n (clkgen_w)
  );
  assign clock_generator_reset_n = clkgen_w;

  reset_extender #(.DELAY(PERIPH_CYC), .CW(CNT_W)) u_periph (
    .clk       (sys_clk),
    .in_rst_n  (clkgen_w & combined_rst_n),
    .hold      (1'b0),
    .out_rst_n (periph_w)
  );
  assign peripheral_reset_n = periph_w & combined_rst_n;

  reset_extender #(.DELAY(CORE_CYC), .CW(CNT_W)) u_core (
    .clk       (sys_clk),
    .in_rst_n  (peripheral_reset_n),
    .hold      (1'b0),
    .out_rst_n (core_w)
  );
  assign core_rst_n = core_w & peripheral_reset_n;
  assign core_run   = core_rst_n;

  assign fast_timer_clk_en = fast_clk_sel & peripheral_reset_n;

  // assertions; each reset stays asserted through count minus one cycles, released at the count
  localparam int POR_LAST    = int'(POR_CYC) - 1;
  localparam int CLKGEN_LAST = int'(CLKGEN_CYC) - 1;
  localparam int PERIPH_LAST = int'(PERIPH_CYC) - 1;
  localparam int CORE_LAST   = int'(CORE_CYC) - 1;

  property p_tap_por;
    @(posedge mclk) tap_rst_n == rst_n;
  endproperty
  a_tap_por: assert property (p_tap_por) else $error("tap reset not power-on");

  property p_por_hold;
    @(posedge mclk) disable iff (!rst_n) $rose(rst_n) |-> !ext_por_rst_n [*8];
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("por released early");

  property p_por_rel;
    @(posedge mclk) disable iff (!rst_n)
      $rose(rst_n) |-> ##POR_LAST !ext_por_rst_n ##1 ext_por_rst_n;
  endproperty
  a_por_rel: assert property (p_por_rel) else $error("por not released");

  property p_comb;
    @(posedge mclk) !ext_rst_n |-> !combined_rst_n && !core_rst_n;
  endproperty
  a_comb: assert property (p_comb) else $error("combined not asserted");

  property p_restart;
    @(posedge mclk) !combined_rst_n |->
      !sync_logic_rst_n && !clock_generator_reset_n && !peripheral_reset_n && !core_rst_n;
  endproperty
  a_restart: assert property (p_restart) else $error("downstream reset not held");

  property p_tap_ext;
    @(posedge mclk) disable iff (!rst_n) !combined_rst_n |-> tap_rst_n;
  endproperty
  a_tap_ext: assert property (p_tap_ext) else $error("tap reset by other source");

  property p_sync;
    @(posedge mclk) disable iff (!combined_rst_n)
      $rose(combined_rst_n) |-> !sync_logic_rst_n ##[1:4] sync_logic_rst_n;
  endproperty
  a_sync: assert property (p_sync) else $error("sync release timing");

  property p_clkgen;
    @(posedge mclk) disable iff (!combined_rst_n)
      $rose(combined_rst_n) |->
        ##CLKGEN_LAST !clock_generator_reset_n ##1 clock_generator_reset_n;
  endproperty
  a_clkgen: assert property (p_clkgen) else $error("clkgen release timing");

  property p_order;
    @(posedge sys_clk) disable iff (!rst_n)
      (peripheral_reset_n |-> clock_generator_reset_n) and (core_rst_n |-> peripheral_reset_n);
  endproperty
  a_order: assert property (p_order) else $error("release order broken");

  property p_core_dly;
    @(posedge sys_clk) disable iff (!peripheral_reset_n)
      $rose(peripheral_reset_n) |-> ##CORE_LAST !core_rst_n ##1 core_rst_n;
  endproperty
  a_core_dly: assert property (p_core_dly) else $error("core released early");

  property p_periph_dly;
    @(posedge sys_clk) disable iff (!combined_rst_n)
      $rose(clock_generator_reset_n) |-> ##PERIPH_LAST !peripheral_reset_n ##1 peripheral_reset_n;
  endproperty
  a_periph_dly: assert property (p_periph_dly) else $error("peripheral release timing");

  property p_sw_take;
    @(posedge mclk) disable iff (!rst_n)
      sync_logic_rst_n && (sw_reset_req || watchdog_timeout_reset ||
      watchdog_lost_reference_reset) |=> !combined_rst_n;
  endproperty
  a_sw_take: assert property (p_sw_take) else $error("sync request not taken");

  property p_refuse;
    @(posedge mclk) disable iff (!rst_n)
      combined_rst_n && !sync_logic_rst_n |=> combined_rst_n || !ext_rst_n;
  endproperty
  a_refuse: assert property (p_refuse) else $error("request taken while held");

  property p_fast;
    @(posedge mclk) fast_timer_clk_en |-> fast_clk_sel && peripheral_reset_n;
  endproperty
  a_fast: assert property (p_fast) else $error("fast clock enabled in reset");

  property p_irq;
    @(posedge mclk) irq == 1'b0;
  endproperty
  a_irq: assert property (p_irq) else $error("irq raised");

  c_por:  cover property (@(posedge mclk) $rose(ext_por_rst_n));
  c_core: cover property (@(posedge sys_clk) $rose(core_rst_n));
  c_sw:   cover property (@(posedge mclk) $fell(combined_rst_n) && ext_rst_n && ext_por_rst_n);
  c_refuse: cover property (@(posedge mclk) combined_rst_n && !sync_logic_rst_n && sw_reset_req);
endmodule : phased_reset_release_sequencer

/* File: test/far_side_model.sv */
`timescale 1ns/1ns
module far_side_model (
  input  wire logic mclk,
  input  wire logic clock_generator_reset_n,
  output logic      sys_clk
);
  // system clock stands low until the clock generator is out of reset
  initial sys_clk = 1'b0;
  always @(posedge mclk) begin
    sys_clk <= clock_generator_reset_n ? ~sys_clk : 1'b0;
  end
endmodule : far_side_model

/* File: test/phased_reset_release_sequencer_tb.sv */
`timescale 1ns/1ns
module phased_reset_release_sequencer_tb;
  import reset_seq_pkg::*;
  localparam int unsigned PC = 8;
  localparam int unsigned CC = 6;
  localparam int unsigned DC = 4;
  logic mclk, sys_clk, rst_n, ext_rst_n, sw, wto, wlr, fsel;
  logic tap, xpor, comb, syn, cg, per, core, run, fen, irq;
  int   n_fail, total_checks, cyc;
  phased_reset_release_sequencer #(.POR_CYC(PC), .SYNC_CYC(3), .CLKGEN_CYC(CC),
    .PERIPH_CYC(DC), .CORE_CYC(DC)) phased_reset_release_sequencer_inst (
    .mclk(mclk), .sys_clk(sys_clk), .rst_n(rst_n), .ext_rst_n(ext_rst_n),
    .sw_reset_req(sw), .watchdog_timeout_reset(wto), .watchdog_lost_reference_reset(wlr),
    .fast_clk_sel(fsel), .tap_rst_n(tap), .ext_por_rst_n(xpor), .combined_rst_n(comb),
    .sync_logic_rst_n(syn), .clock_generator_reset_n(cg), .peripheral_reset_n(per),
    .core_rst_n(core), .core_run(run), .fast_timer_clk_en(fen), .irq(irq));
  far_side_model far_side_model_inst (.mclk(mclk), .clock_generator_reset_n(cg),
    .sys_clk(sys_clk));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic check(input logic seen, input logic exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %b want %b", $time, seen, exp);
    end
  endtask : check
  function logic sel(input int k);
    case (k)
      0: return xpor;
      1: return cg;
      2: return per;
      3: return core;
      4: return syn;
      default: return comb;
    endcase
  endfunction : sel
  task wait_hi(input int k, output int n);
    n = 0;
    while (sel(k) !== 1'b1 && n < 500) begin
      @(posedge mclk);
      n++;
    end
    #1;
  endtask : wait_hi
  always @(posedge cg) check(mclk, 1'b0);
  always @(posedge per) check(sys_clk, 1'b0);
  always @(posedge core) check(sys_clk, 1'b0);
  task t_seq;
    int a, b;
    wait_hi(4, a);
    check(a inside {[2:4]}, 1'b1);
    wait_hi(1, b);
    check((a + b) inside {[CC - 1:CC + 1]}, 1'b1);
    check(per, 1'b0);
    wait_hi(2, a);
    check(a inside {[2 * DC - 2:2 * DC + 2]}, 1'b1);
    check(core, 1'b0);
    wait_hi(3, a);
    check(a inside {[2 * DC - 2:2 * DC + 2]}, 1'b1);
    check(run, 1'b1);
    check(fen, fsel);
    check(irq, 1'b0);
  endtask : t_seq
  task t_por;
    int n;
    check(tap, 1'b0);
    check(core, 1'b0);
    @(posedge mclk) #1 rst_n = 1'b1;
    wait_hi(0, n);
    check(n inside {[PC - 1:PC + 1]}, 1'b1);
    check(comb, 1'b1);
    t_seq();
  endtask : t_por
  task t_src(input int k);
    int n;
    @(posedge mclk) #1 {sw, wto, wlr, ext_rst_n} = 4'h8 >> k ^ 4'h1;
    @(posedge mclk) #1;
    check(comb, 1'b0);
    check(cg | per | core | fen, 1'b0);
    check(tap, 1'b1);
    repeat (2) @(posedge mclk);
    #1 check(comb, k < 3);
    {sw, wto, wlr, ext_rst_n} = 4'h1;
    wait_hi(5, n);
    t_seq();
  endtask : t_src
  task t_restart;
    int n;
    @(posedge mclk) #1 ext_rst_n = 1'b0;
    @(posedge mclk) #1 ext_rst_n = 1'b1;
    wait_hi(1, n);
    @(posedge mclk) #1 ext_rst_n = 1'b0;
    #1 check(cg | per | core, 1'b0);
    @(posedge mclk) #1 ext_rst_n = 1'b1;
    t_seq();
  endtask : t_restart
  initial begin
    {rst_n, ext_rst_n, sw, wto, wlr, fsel} = 6'h10;
    repeat (8) @(posedge mclk);
    #1 t_por();
    fsel = 1'b1;
    for (int k = 0; k < 4; k++) t_src(k);
    t_restart();
    wrap_up();
  end
endmodule : phased_reset_release_sequencer_tb
